// file: design/cos_output_ctrl.sv
// Contract
// - Replicate on: transmit port 1 carries exactly port 0 output.
// - Replicate on also enables the port 1 clock lane while the power-down pin is high.
// - Power-down pin high, sleep-select 0: all lanes held at HS-0.
// - Sleep-select 1, output-enable 0: all pins high impedance.
// - Both set, inactive mode 0, no active input: high impedance.
// - Both set: LP-11 when inactive mode 1 idle, or active input disabled.
// - Both set, active mapped input forwarding enabled: valid traffic.
// - An input is active only while its receiver reports lock.
// - Transmit lock valid when any mapped receive port reports lock.
// - Pass bit set on valid forwarding, cleared when idle or on errors.
// - Sync bit shows synchronized forwarding, zero while it is disabled.
// - Status routable to an output pin, change event raised.
// - One 16 kB line buffer per receive port, two in total.
// - Packet read out only after it is stored entirely.
// - Received long packets counted as lines, high and low byte.
// - Bytes per received line measured, high and low byte.
// - Counts valid only for a single stream per receive port.
`timescale 1ns/1ns
module cos_output_ctrl
  import cos_pkg::*;
(
  input  wire logic           clk_sys_i,
  input  wire logic           rst_i,
  input  wire logic           clk_link_i,
  input  wire logic           power_down_pin_i,
  input  wire logic           scl_i,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe_o,
  input  wire logic [1:0]     rx_lock_i,
  input  wire cos_rx_s [1:0]  rx_i,
  output cos_tx_s [1:0]       tx_o,
  output cos_pin_e [1:0]      tx_pin_state_o,
  output logic [1:0]          tx_clk_lane_en_o,
  output logic                tx_enable_o,
  output logic [1:0]          tx_lane_count_o,
  output logic                status_gpio_o,
  output logic                status_event_o
);

  typedef enum {I_IDLE, I_ADDR, I_AACK, I_WDATA, I_WACK, I_RDATA, I_RACK} cos_i2c_e;

  typedef struct packed {
    logic        pdb_s1;
    logic        pdb_s2;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_p;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_p;
    logic [1:0]  lock_s1;
    logic [1:0]  lock_s2;
    logic [1:0]  pass_s1;
    logic [1:0]  pass_s2;
    logic        req_s1;
    logic        req_s2;
    logic        ack;
    cos_i2c_e    i2c;
    logic [2:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        rw;
    logic        first;
    logic        more;
    logic        drv;
    logic [7:0]  gen;
    logic [7:0]  fwd_dis;
    logic [7:0]  fwd_mode;
    logic [7:0]  tx_ctl;
    cos_lines_s  lines;
    cos_pin_e [1:0] pin;
    logic [1:0]  clk_en;
    logic [2:0]  stat;
    logic        event_p;
  } cos_sys_s;

  typedef struct packed {
    cos_cfg_s       cfg_s1;
    cos_cfg_s       cfg_s2;
    logic           ack_s1;
    logic           ack_s2;
    logic           req;
    cos_lines_s     snap;
    logic [1:0]     busy;
    logic [1:0]     sel;
    logic [1:0]     last_p;
    logic [1:0]     pass;
    cos_tx_s [1:0]  tx;
  } cos_lnk_s;

  cos_sys_s   s_q;
  cos_sys_s   s_d;
  cos_lnk_s   l_q;
  cos_lnk_s   l_d;
  logic       rst_l_s1;
  logic       rst_link;
  logic [1:0] rd_valid;
  logic [1:0] rd_last;
  logic [1:0] rd_ready;
  logic [1:0] line_done;
  logic [7:0] rd_data [2];
  cos_lines_s lines [2];
  cos_cfg_s   cfg_sys;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic cos_pin_e pin_state(logic power_down_pin, logic oss, logic output_drive_enable, logic mode,
                                         logic any_act, logic any_fwd);
    if (!power_down_pin)
      return PIN_HIZ;
    else if (!oss)
      return PIN_HS0;
    else if (!output_drive_enable)
      return PIN_HIZ;
    else if (any_fwd)
      return PIN_VALID;
    else if (any_act)
      return PIN_LP11;
    else if (mode)
      return PIN_LP11;
    else
      return PIN_HIZ;
  endfunction : pin_state

  function automatic logic [7:0] reg_read(cos_sys_s s, logic [7:0] a);
    case (a)
      REG_GEN:      return s.gen;
      REG_FWD_DIS:  return s.fwd_dis;
      REG_FWD_MODE: return s.fwd_mode;
      REG_TX_CTL:   return s.tx_ctl;
      REG_TX_STATE: return {5'h00, s.stat};
      REG_LINES_HI: return s.lines.lines[15:8];
      REG_LINES_LO: return s.lines.lines[7:0];
      REG_LEN_HI:   return s.lines.len[15:8];
      REG_LEN_LO:   return s.lines.len[7:0];
      default:      return 8'h00;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Register port and output state, system clock
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic [7:0] byte_v;
    logic [7:0] rd_v;
    logic [1:0] mapped;
    logic [2:0] stat;
    logic       pass;
    s_d = s_q;
    byte_v = {s_q.shift[6:0], s_q.sda_s2};
    rd_v = reg_read(s_q, s_q.ptr);
    mapped = 2'b00;
    stat = 3'h0;
    pass = 1'b0;
    s_d.pdb_s1  = power_down_pin_i;
    s_d.pdb_s2  = s_q.pdb_s1;
    s_d.scl_s1  = scl_i;
    s_d.scl_s2  = s_q.scl_s1;
    s_d.scl_p   = s_q.scl_s2;
    s_d.sda_s1  = sda_i;
    s_d.sda_s2  = s_q.sda_s1;
    s_d.sda_p   = s_q.sda_s2;
    s_d.lock_s1 = rx_lock_i;
    s_d.lock_s2 = s_q.lock_s1;
    s_d.pass_s1 = l_q.pass;
    s_d.pass_s2 = s_q.pass_s1;
    s_d.req_s1  = l_q.req;
    s_d.req_s2  = s_q.req_s1;
    scl_rise = s_q.scl_s2 && !s_q.scl_p;
    scl_fall = !s_q.scl_s2 && s_q.scl_p;
    start = s_q.scl_s2 && s_q.scl_p && s_q.sda_p && !s_q.sda_s2;
    stop  = s_q.scl_s2 && s_q.scl_p && !s_q.sda_p && s_q.sda_s2;
    // Line figures taken over once the link side holds them still
    if (s_q.req_s2 != s_q.ack)
    begin
      s_d.lines = l_q.snap;
      s_d.ack   = s_q.req_s2;
    end
    unique case (s_q.i2c)
      I_IDLE:
      begin
      end
      I_ADDR, I_WDATA:
      begin
        if (scl_rise)
        begin
          s_d.shift  = byte_v;
          s_d.bitcnt = s_q.bitcnt + 3'h1;
          if (s_q.bitcnt == 3'h7)
          begin
            if (s_q.i2c == I_ADDR)
            begin
              s_d.rw  = byte_v[0];
              s_d.i2c = (byte_v[7:1] == I2C_DEV_ADDR) ? I_AACK : I_IDLE;
            end
            else
            begin
              s_d.i2c   = I_WACK;
              s_d.first = 1'b0;
              if (s_q.first)
              begin
                s_d.ptr = byte_v;
              end
              else
              begin
                s_d.ptr = s_q.ptr + 8'h01;
                case (s_q.ptr)
                  REG_GEN:      s_d.gen      = byte_v;
                  REG_FWD_DIS:  s_d.fwd_dis  = byte_v;
                  REG_FWD_MODE: s_d.fwd_mode = byte_v;
                  REG_TX_CTL:   s_d.tx_ctl   = byte_v;
                  default:      s_d.ptr      = s_q.ptr + 8'h01;
                endcase
              end
            end
          end
        end
      end
      I_AACK, I_WACK:
      begin
        if (scl_fall)
        begin
          s_d.drv    = !s_q.drv;
          s_d.bitcnt = 3'h0;
          if (s_q.drv)
          begin
            if (s_q.i2c == I_AACK && s_q.rw)
            begin
              s_d.shift = rd_v;
              s_d.ptr   = s_q.ptr + 8'h01;
              s_d.drv   = !rd_v[7];
              s_d.i2c   = I_RDATA;
            end
            else
            begin
              s_d.i2c = I_WDATA;
            end
          end
        end
      end
      I_RDATA:
      begin
        if (scl_fall)
        begin
          if (s_q.bitcnt == 3'h7)
          begin
            s_d.drv = 1'b0;
            s_d.i2c = I_RACK;
          end
          else
          begin
            s_d.shift  = {s_q.shift[6:0], 1'b0};
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            s_d.drv    = !s_q.shift[6];
          end
        end
      end
      I_RACK:
      begin
        if (scl_rise)
        begin
          s_d.more = !s_q.sda_s2;
        end
        if (scl_fall)
        begin
          if (s_q.more)
          begin
            s_d.shift  = rd_v;
            s_d.ptr    = s_q.ptr + 8'h01;
            s_d.drv    = !rd_v[7];
            s_d.bitcnt = 3'h0;
            s_d.i2c    = I_RDATA;
          end
          else
          begin
            s_d.i2c = I_IDLE;
          end
        end
      end
    endcase
    if (start)
    begin
      s_d.i2c    = I_ADDR;
      s_d.bitcnt = 3'h0;
      s_d.first  = 1'b1;
      s_d.drv    = 1'b0;
    end
    else if (stop)
    begin
      s_d.i2c = I_IDLE;
      s_d.drv = 1'b0;
    end
    // Pin state per transmit port
    for (int k = 0; k < 2; k++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        mapped[p] = s_q.fwd_dis[FWD_MAP_LSB + p] == 1'(k);
      end
      s_d.pin[k] = pin_state(s_q.pdb_s2, s_q.gen[GEN_OSS_BIT], s_q.gen[GEN_OEN_BIT],
                             s_q.gen[GEN_MODE_BIT],
                             |(s_q.lock_s2 & mapped),
                             |(s_q.lock_s2 & mapped & ~s_q.fwd_dis[FWD_DIS_LSB +: 2]));
    end
    if (s_q.fwd_mode[MODE_REPL_BIT])
    begin
      s_d.pin[1] = s_d.pin[0];
    end
    for (int k = 0; k < 2; k++)
    begin
      s_d.clk_en[k] = s_d.pin[k] == PIN_LP11 || s_d.pin[k] == PIN_VALID;
    end
    s_d.clk_en[1] = s_d.clk_en[1] || (s_q.fwd_mode[MODE_REPL_BIT] && s_q.pdb_s2);
    // Status
    pass = s_q.pin[0] == PIN_VALID && s_q.pass_s2[0];
    stat[ST_PASS0_BIT] = pass;
    stat[ST_PASS1_BIT] = s_q.pin[1] == PIN_VALID && s_q.pass_s2[1];
    stat[ST_SYNC_BIT] = s_q.fwd_mode[MODE_SYNC_BIT] && pass &&
                        (&(s_q.lock_s2 & ~s_q.fwd_dis[FWD_DIS_LSB +: 2]));
    s_d.stat    = stat;
    s_d.event_p = stat != s_q.stat;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_q          <= '0;
      s_q.pdb_s1   <= 1'b0;
      s_q.scl_s1   <= 1'b1;
      s_q.scl_s2   <= 1'b1;
      s_q.scl_p    <= 1'b1;
      s_q.sda_s1   <= 1'b1;
      s_q.sda_s2   <= 1'b1;
      s_q.sda_p    <= 1'b1;
      s_q.i2c      <= I_IDLE;
      s_q.gen      <= GEN_RST;
      s_q.fwd_dis  <= FWD_DIS_RST;
      s_q.fwd_mode <= FWD_MODE_RST;
      s_q.tx_ctl   <= TXC_RST;
      s_q.pin      <= {PIN_HIZ, PIN_HIZ};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_sys = '{repl: s_q.fwd_mode[MODE_REPL_BIT],
                     dis:  s_q.fwd_dis[FWD_DIS_LSB +: 2],
                     map:  s_q.fwd_dis[FWD_MAP_LSB +: 2]};

  assign sda_o            = 1'b0;
  assign sda_oe_o         = s_q.drv;
  assign tx_pin_state_o   = s_q.pin;
  assign tx_clk_lane_en_o = s_q.clk_en;
  assign tx_enable_o      = s_q.tx_ctl[TXC_EN_BIT];
  assign tx_lane_count_o  = s_q.tx_ctl[TXC_LANES_LSB +: 2];
  assign status_gpio_o    = s_q.gen[GEN_GPIO_SEL_BIT] ? s_q.stat[ST_SYNC_BIT]
                                                      : s_q.stat[ST_PASS0_BIT];
  assign status_event_o   = s_q.event_p;

  // ----------------------------------------------------------------
  // Receive buffers, link clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_link_i)
  begin
    rst_l_s1 <= rst_i;
    rst_link <= rst_l_s1;
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_rx
    cos_rx_path u_rx (
      .clk_link_i  (clk_link_i),
      .rst_link_i  (rst_link),
      .rx_i        (rx_i[p]),
      .rd_ready_i  (rd_ready[p]),
      .rd_valid_o  (rd_valid[p]),
      .rd_data_o   (rd_data[p]),
      .rd_last_o   (rd_last[p]),
      .line_done_o (line_done[p]),
      .lines_o     (lines[p])
    );
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_rdy
    assign rd_ready[p] = (l_q.busy[0] && l_q.sel[0] == 1'(p)) ||
                         (l_q.busy[1] && l_q.sel[1] == 1'(p));
  end

  // ----------------------------------------------------------------
  // Forwarding engines, link clock
  // ----------------------------------------------------------------
  always_comb
  begin
    logic cand;
    logic pick;
    logic pp;
    l_d = l_q;
    cand = 1'b0;
    pick = 1'b0;
    pp = 1'b0;
    l_d.cfg_s1 = cfg_sys;
    l_d.cfg_s2 = l_q.cfg_s1;
    l_d.ack_s1 = s_q.ack;
    l_d.ack_s2 = l_q.ack_s1;
    // Port 0 figures only; several channels on one port mix them up
    if (line_done[0] && l_q.req == l_q.ack_s2)
    begin
      l_d.snap = lines[0];
      l_d.req  = !l_q.req;
    end
    for (int k = 0; k < 2; k++)
    begin
      l_d.tx[k] = '0;
      pick = 1'b0;
      if (l_q.busy[k])
      begin
        pp = l_q.sel[k];
        if (rd_valid[pp])
        begin
          l_d.tx[k] = '{valid: 1'b1, last: rd_last[pp], data: rd_data[pp]};
          if (rd_last[pp])
          begin
            l_d.busy[k]   = 1'b0;
            l_d.last_p[k] = pp;
            l_d.pass[k]   = 1'b1;
          end
        end
      end
      else if (!(k == 1 && l_q.cfg_s2.repl))
      begin
        for (int j = 0; j < 2; j++)
        begin
          pp = (j == 0) ? !l_q.last_p[k] : l_q.last_p[k];
          cand = rd_valid[pp] && l_q.cfg_s2.map[pp] == 1'(k) &&
                 !l_q.cfg_s2.dis[pp] && rx_lock_i[pp];
          if (cand && !pick)
          begin
            pick          = 1'b1;
            l_d.busy[k]   = 1'b1;
            l_d.sel[k]    = pp;
          end
        end
      end
      for (int p = 0; p < 2; p++)
      begin
        if (l_q.cfg_s2.map[p] == 1'(k) && rx_i[p].valid && rx_i[p].err &&
            !(l_q.busy[k] && !l_d.busy[k]))
        begin
          l_d.pass[k] = 1'b0;
        end
      end
      if (!(|(rx_lock_i & ~l_q.cfg_s2.dis &
              {l_q.cfg_s2.map[1] == 1'(k), l_q.cfg_s2.map[0] == 1'(k)})))
      begin
        l_d.pass[k] = 1'b0;
      end
    end
    if (l_q.cfg_s2.repl)
    begin
      l_d.tx[1]   = l_d.tx[0];
      l_d.pass[1] = l_d.pass[0];
      l_d.busy[1] = 1'b0;
    end
  end

  always_ff @(posedge clk_link_i)
  begin
    if (rst_link)
    begin
      l_q <= '0;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  assign tx_o = l_q.tx;

endmodule : cos_output_ctrl

// file: design/cos_pkg.sv
package cos_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_GEN      = 8'h02;
  localparam logic [7:0] REG_FWD_DIS  = 8'h20;
  localparam logic [7:0] REG_FWD_MODE = 8'h21;
  localparam logic [7:0] REG_TX_CTL   = 8'h33;
  localparam logic [7:0] REG_TX_STATE = 8'h35;
  localparam logic [7:0] REG_LINES_HI = 8'h73;
  localparam logic [7:0] REG_LINES_LO = 8'h74;
  localparam logic [7:0] REG_LEN_HI   = 8'h75;
  localparam logic [7:0] REG_LEN_LO   = 8'h76;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEN_OEN_BIT      = 2;
  localparam int GEN_OSS_BIT      = 3;
  localparam int GEN_MODE_BIT     = 4;
  localparam int GEN_GPIO_SEL_BIT = 7;
  localparam int FWD_MAP_LSB      = 0;
  localparam int FWD_DIS_LSB      = 4;
  localparam int MODE_SYNC_BIT    = 2;
  localparam int MODE_REPL_BIT    = 7;
  localparam int TXC_EN_BIT       = 0;
  localparam int TXC_LANES_LSB    = 4;
  localparam int ST_PASS0_BIT     = 0;
  localparam int ST_SYNC_BIT      = 1;
  localparam int ST_PASS1_BIT     = 2;

  // ----------------------------------------------------------------
  // Values after reset, and the register port device address
  // ----------------------------------------------------------------
  localparam logic [7:0] GEN_RST      = 8'h0c;
  localparam logic [7:0] FWD_DIS_RST  = 8'h30;
  localparam logic [7:0] FWD_MODE_RST = 8'h00;
  localparam logic [7:0] TXC_RST      = 8'h00;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h3d;

  // ----------------------------------------------------------------
  // Video buffer size
  // ----------------------------------------------------------------
  localparam int BUF_BYTES = 16384;
  localparam int BUF_AW    = 14;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PIN_HIZ, PIN_HS0, PIN_LP11, PIN_VALID} cos_pin_e;

  typedef struct packed {
    logic       valid;
    logic       fs;
    logic       long_pkt;
    logic       last;
    logic       err;
    logic [7:0] data;
  } cos_rx_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } cos_tx_s;

  typedef struct packed {
    logic [15:0] lines;
    logic [15:0] len;
  } cos_lines_s;

  typedef struct packed {
    logic       repl;
    logic [1:0] dis;
    logic [1:0] map;
  } cos_cfg_s;

endpackage : cos_pkg

// file: design/cos_rx_path.sv
`timescale 1ns/1ns
module cos_rx_path
  import cos_pkg::*;
(
  input  wire logic        clk_link_i,
  input  wire logic        rst_link_i,
  input  wire cos_rx_s     rx_i,
  input  wire logic        rd_ready_i,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_last_o,
  output logic             line_done_o,
  output cos_lines_s       lines_o
);

  typedef struct packed {
    logic [BUF_AW:0] wptr;
    logic [BUF_AW:0] cptr;
    logic [BUF_AW:0] rptr;
    logic [15:0]     bytes;
    logic            drop;
    logic            done;
    cos_lines_s      cnt;
  } cos_buf_s;

  cos_buf_s   q;
  cos_buf_s   n;
  logic [8:0] mem [BUF_BYTES];
  logic       full;

  // ----------------------------------------------------------------
  // Packet store and counters
  // ----------------------------------------------------------------
  always_comb
  begin
    n = q;
    n.done = 1'b0;
    full = (q.wptr - q.rptr) == (BUF_AW + 1)'(BUF_BYTES);
    if (rx_i.fs)
    begin
      n.cnt.lines = 16'h0000;
    end
    if (rx_i.valid)
    begin
      if (full)
      begin
        n.drop = 1'b1;
      end
      else
      begin
        n.wptr  = q.wptr + 15'h0001;
        n.bytes = q.bytes + 16'h0001;
      end
      if (rx_i.last)
      begin
        if (rx_i.err || q.drop || full)
        begin
          n.wptr = q.cptr;
        end
        else
        begin
          n.cptr = q.wptr + 15'h0001;
          if (rx_i.long_pkt)
          begin
            n.cnt.lines = q.cnt.lines + 16'h0001;
            n.cnt.len   = q.bytes + 16'h0001;
            n.done      = 1'b1;
          end
        end
        n.bytes = 16'h0000;
        n.drop  = 1'b0;
      end
    end
    if (rd_ready_i && rd_valid_o)
    begin
      n.rptr = q.rptr + 15'h0001;
    end
  end

  always_ff @(posedge clk_link_i)
  begin
    if (rst_link_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Buffer array
  // ----------------------------------------------------------------
  always_ff @(posedge clk_link_i)
  begin
    if (rx_i.valid && !full && !q.drop)
    begin
      mem[q.wptr[BUF_AW-1:0]] <= {rx_i.last, rx_i.data};
    end
  end

  assign rd_valid_o  = q.rptr != q.cptr;
  assign rd_data_o   = mem[q.rptr[BUF_AW-1:0]][7:0];
  assign rd_last_o   = mem[q.rptr[BUF_AW-1:0]][8];
  assign line_done_o = q.done;
  assign lines_o     = q.cnt;

endmodule : cos_rx_path

// file: tb/cos_output_ctrl_checker.sv
`timescale 1ns/1ns
module cos_output_ctrl_checker
  import cos_pkg::*;
(
  input wire logic           clk_sys_i,
  input wire logic           rst_i,
  input wire logic           clk_link_i,
  input wire logic           power_down_pin_i,
  input wire logic [1:0]     rx_lock_i,
  input wire cos_tx_s [1:0]  tx_o,
  input wire cos_pin_e [1:0] tx_pin_state_o,
  input wire logic [1:0]     tx_clk_lane_en_o
);
  // ------------------------
  // Powered-down cycle count
  // ------------------------
  logic [2:0] low_q;
  logic [2:0] low_d;
  always_comb
  begin
    low_d = power_down_pin_i ? 3'h0 : low_q + 3'(low_q != 3'h7);
  end
  always_ff @(posedge clk_sys_i)
  begin
    low_q <= rst_i ? 3'h0 : low_d;
  end
  // ------
  // Checks
  // ------
  sequence s_mid(k);
    tx_o[k].valid && !tx_o[k].last;
  endsequence
  AST_PDB_HIZ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    low_q > 3'h3 |-> tx_pin_state_o == {PIN_HIZ, PIN_HIZ}) else $error("pins driven");
  AST_PDB_CLK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    low_q > 3'h3 |-> tx_clk_lane_en_o == 2'h0) else $error("clock lane on");
  AST_NOLOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rx_lock_i == 2'h0) [*5] |-> tx_pin_state_o[0] != PIN_VALID
    && tx_pin_state_o[1] != PIN_VALID) else $error("traffic without lock");
  AST_CLK_ON0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_pin_state_o[0] inside {PIN_LP11, PIN_VALID}) [*2] |-> tx_clk_lane_en_o[0])
    else $error("port 0 clock lane off");
  AST_CLK_OFF0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_pin_state_o[0] inside {PIN_HIZ, PIN_HS0}) [*2] |-> !tx_clk_lane_en_o[0])
    else $error("port 0 clock lane on");
  AST_CLK_ON1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_pin_state_o[1] inside {PIN_LP11, PIN_VALID}
    && $past(tx_pin_state_o[1]) inside {PIN_LP11, PIN_VALID} |-> tx_clk_lane_en_o[1])
    else $error("port 1 clock lane off");
  AST_TX_GAP0: assert property (@(posedge clk_link_i) disable iff (rst_i)
    s_mid(0) |=> tx_o[0].valid) else $error("gap in port 0 packet");
  AST_TX_GAP1: assert property (@(posedge clk_link_i) disable iff (rst_i)
    s_mid(1) |=> tx_o[1].valid) else $error("gap in port 1 packet");
  AST_TX_LAST: assert property (@(posedge clk_link_i) disable iff (rst_i)
    tx_o[0].last || tx_o[1].last |-> (tx_o[0].valid || !tx_o[0].last)
    && (tx_o[1].valid || !tx_o[1].last)) else $error("end without byte");
endmodule : cos_output_ctrl_checker

bind cos_output_ctrl cos_output_ctrl_checker chk_i (.clk_sys_i, .rst_i, .clk_link_i,
  .power_down_pin_i, .rx_lock_i, .tx_o, .tx_pin_state_o, .tx_clk_lane_en_o);

// file: tb/cos_far_end.sv
`timescale 1ns/1ns
module cos_far_end
  import cos_pkg::*;
(
  input wire logic          clk_link_i,
  input wire cos_tx_s [1:0] tx_i
);
  // ------------------------------
  // Byte capture per transmit port
  // ------------------------------
  logic [7:0] got0[$];
  logic [7:0] got1[$];
  always @(posedge clk_link_i)
  begin
    if (tx_i[0].valid === 1'b1)
      got0.push_back(tx_i[0].data);
    if (tx_i[1].valid === 1'b1)
      got1.push_back(tx_i[1].data);
  end
endmodule : cos_far_end

// file: tb/tb_csi2_output_state_status.sv
`timescale 1ns/1ns
module tb_csi2_output_state_status
  import cos_pkg::*;
;
  logic           clk_sys_i = 1'b0;
  logic           clk_link_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           power_down_pin_i = 1'b1;
  logic           scl_i = 1'b1;
  logic           sda_m = 1'b1;
  logic           sda_i;
  logic           sda_o;
  logic           sda_oe_o;
  logic [1:0]     rx_lock_i = 2'h0;
  cos_rx_s [1:0]  rx_i = '0;
  cos_tx_s [1:0]  tx_o;
  cos_pin_e [1:0] tx_pin_state_o;
  logic [1:0]     tx_clk_lane_en_o;
  logic           tx_enable_o;
  logic [1:0]     tx_lane_count_o;
  logic           status_gpio_o;
  logic           status_event_o;
  logic           rb;
  logic [7:0]     d;
  logic [7:0]     t;
  logic [18:0]    r;
  logic [7:0]     q[$];
  int             ln;
  int             nl;
  int             bad_count = 0;
  int             checks = 0;
  int             nev = 0;
  localparam logic [18:0] ROW [7] = '{{1'b0, 8'h1c, 8'h00, 2'h3}, {1'b1, 8'h14, 8'h00, 2'h3},
    {1'b1, 8'h18, 8'h00, 2'h3}, {1'b1, 8'h1c, 8'h30, 2'h0}, {1'b1, 8'h0c, 8'h10, 2'h1},
    {1'b1, 8'h0c, 8'h01, 2'h1}, {1'b1, 8'h0c, 8'h00, 2'h2}};

  always #5 clk_sys_i = ~clk_sys_i;
  always #32 clk_link_i = ~clk_link_i;
  assign sda_i = sda_m & ~sda_oe_o;
  always @(posedge clk_sys_i) nev += int'(status_event_o === 1'b1);

  cos_output_ctrl uut (.clk_sys_i, .rst_i, .clk_link_i, .power_down_pin_i, .scl_i, .sda_i,
    .sda_o, .sda_oe_o, .rx_lock_i, .rx_i, .tx_o, .tx_pin_state_o, .tx_clk_lane_en_o,
    .tx_enable_o, .tx_lane_count_o, .status_gpio_o, .status_event_o);
  cos_far_end far (.clk_link_i, .tx_i(tx_o));

  // -----
  // Tasks
  // -----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic bitw(input logic b);
    sda_m = b;
    cyc(5);
    scl_i = 1'b1;
    cyc(10);
    rb = sda_i;
    scl_i = 1'b0;
    cyc(5);
  endtask : bitw
  task automatic cond(input logic s);
    sda_m = s;
    cyc(5);
    scl_i = 1'b1;
    cyc(10);
    sda_m = !s;
    cyc(10);
    scl_i = !s;
  endtask : cond
  task automatic xfer(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      bitw(v[i]);
      d[i] = rb;
    end
    bitw(1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cond(1'b1);
    xfer({I2C_DEV_ADDR, 1'b0});
    xfer(a);
    xfer(v);
    cond(1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cond(1'b1);
    xfer({I2C_DEV_ADDR, 1'b0});
    xfer(a);
    cond(1'b1);
    xfer({I2C_DEV_ADDR, 1'b1});
    xfer(8'hff);
    cond(1'b0);
  endtask : rd
  task automatic pkt(input int n, input logic e);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_link_i);
      rx_i[0] = '{1'b1, 1'b0, 1'b1, i == n - 1, e && i == n - 1, 8'($urandom)};
      if (!e)
        q.push_back(rx_i[0].data);
    end
    @(negedge clk_link_i);
    rx_i[0] = '0;
  endtask : pkt
  function automatic cos_pin_e pin_of(input logic [18:0] w, input int k);
    logic act;
    logic en;
    act = 1'b0;
    en = 1'b0;
    for (int i = 0; i < 2; i++)
      if (w[i] && w[2 + i] == k[0])
      begin
        act = 1'b1;
        en |= !w[6 + i];
      end
    if (!w[18])
      return PIN_HIZ;
    if (!w[10 + GEN_OSS_BIT])
      return PIN_HS0;
    if (!w[10 + GEN_OEN_BIT])
      return PIN_HIZ;
    if (en)
      return PIN_VALID;
    return (act || w[10 + GEN_MODE_BIT]) ? PIN_LP11 : PIN_HIZ;
  endfunction : pin_of
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // -------------
  // Main sequence
  // -------------
  initial
  begin
    void'($urandom(20809));
    repeat (10) @(negedge clk_link_i);
    rst_i = 1'b0;
    cyc(10);
    chk(16'(tx_pin_state_o), 16'({PIN_HIZ, PIN_HIZ}));
    for (int k = 0; k < 16; k++)
    begin
      r = k < 7 ? ROW[k] : 19'($urandom) & 19'h670cf;
      power_down_pin_i = 1'b1;
      wr(REG_GEN, r[17:10]);
      wr(REG_FWD_DIS, r[9:2]);
      power_down_pin_i = r[18];
      rx_lock_i = r[1:0];
      cyc(8);
      chk(16'(tx_pin_state_o), 16'({pin_of(r, 1), pin_of(r, 0)}));
    end
    power_down_pin_i = 1'b1;
    rx_lock_i = 2'h1;
    wr(REG_GEN, 8'h0c);
    wr(REG_FWD_DIS, 8'h00);
    wr(REG_TX_CTL, 8'h11);
    chk(16'({tx_enable_o, tx_lane_count_o}), 16'h5);
    @(negedge clk_link_i);
    rx_i[0].fs = 1'b1;
    @(negedge clk_link_i);
    rx_i[0].fs = 1'b0;
    nl = 0;
    for (int k = 0; k < 6; k++)
    begin
      ln = 2 + $urandom_range(30);
      pkt(ln, k == 2);
      nl += int'(k != 2);
    end
    repeat (50) @(negedge clk_link_i);
    chk(16'(far.got0.size()), 16'(q.size()));
    foreach (q[i])
      chk(16'(far.got0[i]), 16'(q[i]));
    rd(REG_TX_STATE);
    chk(16'(d[2:0]), 16'h1);
    chk(16'(status_gpio_o), 16'h1);
    rx_lock_i = 2'h3;
    wr(REG_FWD_MODE, 8'h04);
    wr(REG_GEN, 8'h8c);
    rd(REG_TX_STATE);
    chk(16'({status_gpio_o, d[2:0]}), 16'hb);
    rd(REG_LINES_HI);
    t = d;
    rd(REG_LINES_LO);
    chk({t, d}, 16'(nl));
    rd(REG_LEN_HI);
    t = d;
    rd(REG_LEN_LO);
    chk({t, d}, 16'(ln));
    pkt(4, 1'b1);
    rd(REG_TX_STATE);
    chk(16'(d[0]), 16'h0);
    wr(REG_FWD_MODE, 8'h80);
    q.delete();
    pkt(9, 1'b0);
    repeat (20) @(negedge clk_link_i);
    chk(16'(far.got1.size()), 16'h9);
    foreach (q[i])
      chk(16'(far.got1[i]), 16'(q[i]));
    chk(16'(tx_pin_state_o), 16'({PIN_VALID, PIN_VALID}));
    ln = nev;
    rx_lock_i = 2'h0;
    cyc(8);
    chk(16'(tx_clk_lane_en_o), 16'h2);
    chk(16'(nev - ln), 16'h1);
    report_and_stop();
  end

  initial
  begin
    #600000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb_csi2_output_state_status
